// file: core/gated_sixteen_bit_timer.sv
// Behaviour
// (RL1) 16-bit up-counter seen as two bytes; byte writes replace that part at once.
// (RL2) source and alternate bits select fosc/4, fosc or the external count pin.
// (RL3) internal source advances once per prescaled instruction-cycle multiple.
// (RL4) external source in counting use advances on each rising edge of the pin.
// (RL5) external count may be resynchronized or drive the counter asynchronously; here both paths are sampled on clk_i.
// (RL6) with internal oscillator and no clock out, crystal can be the count clock.
// (RL7) rising edges ignored until one falling edge after enable, write or re-enable; here re-enable needs it only after stop-high, start-low.
// (RL8) two-bit prescale field divides the chosen clock by 1, 2, 4 or 8.
// (RL9) prescale counter hidden from software; any count byte write clears it.
// (RL10) crystal enable bit starts the 32.768 kHz oscillator; it runs in sleep.
// (RL11) crystal only usable when the system runs from internal or low-power oscillator.
// (RL12) crystal enabled forces pin5/pin4 direction to one and data reads to zero.
// (RL13) software sets crystal enable and waits for start-up before enabling counter.
// (RL14) sync disable bit bypasses resynchronization; count runs asynchronous to phases; here it only skips the agreement filter on clk_i.
// (RL15) asynchronous counting runs during sleep; wrap raises a wake-capable interrupt.
// (RL16) sync/async switching may lose or add one increment.
// (RL17) async or fosc-clocked counting is no capture/compare time base; here fosc drops timebase_valid_o only with internal_oscillator_mode set.
// (RL18) counter wraps from maximum to zero and each wrap sets the wrap flag.
// (RL19) run enable set starts counting, cleared stops it.
// (RL20) prescale field: 11 is 1:8, 10 is 1:4, 01 is 1:2, 00 is 1:1.
`timescale 1ns/1ps
`default_nettype none
module gated_sixteen_bit_timer (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic external_count_pin_i,
  input wire logic crystal_clock_i,
  input wire logic sleep_i,
  input wire logic lp_osc_mode_i,
  input wire logic pin5_direction_sw_i,
  input wire logic pin4_direction_sw_i,
  input wire logic pin5_data_raw_i,
  input wire logic pin4_data_raw_i,
  output logic crystal_osc_enable_o,
  output logic wrap_interrupt_o,
  output logic wake_o,
  output logic timebase_valid_o,
  output gated_timer_pkg::port_view_s port_view_o
);

  gated_timer_pkg::control_s control;
  gated_timer_pkg::bus_state_e bus_state;
  logic [15:0] count;
  logic [2:0] prescale;
  logic [1:0] instr_cnt;
  logic instr_tick;
  logic wrap_interrupt_flag;
  logic ext_s1, ext_s2, ext_s3;
  logic ext_level;
  logic ext_prev;
  logic armed;
  logic run_prev;
  logic ever_enabled;
  logic stop_level;
  logic rearm_needed;
  logic awake;
  logic ext_source;
  logic timebase_next;
  logic count_write;
  logic crystal_usable;
  logic ext_sel;
  logic raw_rise;
  logic raw_fall;
  logic src_tick;
  logic [2:0] prescale_mask;
  logic pre_tick;
  logic count_tick;
  logic bus_hit;
  logic [31:0] next_readdata;
  logic [15:0] next_count;

  // the sync-disable path still passes the pin stages: a single clock domain
  // has no true async count, so async mode only skips the agreement filter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= ext_source;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_level <= 1'b0;
    end else if (control.sync_disable_bit) begin
      ext_level <= ext_s2; // see (RL14)
    end else if (ext_s2 == ext_s3) begin
      ext_level <= ext_s3; // see (RL5)
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  assign raw_rise = ext_level && !ext_prev;
  assign raw_fall = !ext_level && ext_prev;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      instr_cnt <= 2'h0;
    end else if (instr_cnt == gated_timer_pkg::instr_div_last) begin
      instr_cnt <= 2'h0;
    end else begin
      instr_cnt <= instr_cnt + 2'h1;
    end
  end

  assign instr_tick = instr_cnt == gated_timer_pkg::instr_div_last;
  assign crystal_usable = control.internal_oscillator_mode || lp_osc_mode_i; // see (RL11)
  assign ext_sel = control.source_select_bit;
  // crystal and count pin share one synchroniser, so a switch may show a false edge
  assign ext_source = control.crystal_enable_bit && crystal_usable ? crystal_clock_i : external_count_pin_i; // see (RL6)
  // sleep stops the fosc-derived modes; only the unsynchronised pin path runs on
  assign awake = !sleep_i || (ext_sel && control.sync_disable_bit); // see (RL15)
  // fosc clocking from the internal oscillator cannot feed capture/compare
  assign timebase_next = !(ext_sel && control.sync_disable_bit)
    && !(!ext_sel && control.alternate_source_bit && control.internal_oscillator_mode); // see (RL17)

  // only the first start after reset, or a stop while high and start while low,
  // asks for a fresh falling edge; a plain restart keeps the arm
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= control.run_enable_bit;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ever_enabled <= 1'b0;
    end else if (control.run_enable_bit) begin
      ever_enabled <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_level <= 1'b0;
    end else if (!control.run_enable_bit && run_prev) begin
      stop_level <= ext_level; // see (RL7)
    end
  end

  assign rearm_needed = control.run_enable_bit && !run_prev && (!ever_enabled || (stop_level && !ext_level));

  // a count write and a falling edge in one cycle leave it disarmed
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed <= 1'b0;
    end else if (count_write || rearm_needed) begin
      armed <= 1'b0; // see (RL7)
    end else if (raw_fall) begin
      armed <= 1'b1; // see (RL7)
    end
  end

  always_comb begin
    if (ext_sel) begin
      src_tick = raw_rise && armed; // see (RL4)
    end else if (control.alternate_source_bit) begin
      src_tick = 1'b1; // see (RL2)
    end else begin
      src_tick = instr_tick; // see (RL3)
    end
  end

  always_comb begin
    case (control.prescale_select_field) // see (RL20)
      2'b11: prescale_mask = 3'h7;
      2'b10: prescale_mask = 3'h3;
      2'b01: prescale_mask = 3'h1;
      default: prescale_mask = 3'h0;
    endcase
  end

  assign pre_tick = (prescale & prescale_mask) == prescale_mask; // see (RL8)
  assign count_tick = control.run_enable_bit && src_tick && pre_tick && !count_write; // see (RL19)

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prescale <= gated_timer_pkg::prescale_reset;
    end else if (count_write) begin
      prescale <= gated_timer_pkg::prescale_reset; // see (RL9)
    end else if (control.run_enable_bit && src_tick && awake) begin
      prescale <= pre_tick ? 3'h0 : prescale + 3'h1;
    end
  end

  assign bus_hit = bus_state == gated_timer_pkg::bus_ack;
  assign count_write = bus_hit && avs_write_i && avs_byteenable_i[0]
    && (avs_address_i == gated_timer_pkg::count_low_addr || avs_address_i == gated_timer_pkg::count_high_addr);

  always_comb begin
    next_count = count;
    if (count_tick) begin
      next_count = count + 16'h0001; // see (RL18)
    end
    if (count_write && avs_address_i == gated_timer_pkg::count_low_addr) begin
      next_count[7:0] = avs_writedata_i[7:0]; // see (RL1)
    end
    if (count_write && avs_address_i == gated_timer_pkg::count_high_addr) begin
      next_count[15:8] = avs_writedata_i[7:0]; // see (RL1)
    end
  end

  // sleep gates only the synchronous modes; async keeps counting
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= gated_timer_pkg::count_reset;
    end else if (awake || count_write) begin
      count <= next_count; // see (RL15)
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wrap_interrupt_flag <= 1'b0;
    end else if (count_tick && awake && count == 16'hffff) begin
      wrap_interrupt_flag <= 1'b1; // see (RL18)
    end else if (bus_hit && avs_write_i && avs_byteenable_i[0] && avs_address_i == gated_timer_pkg::status_addr
                 && avs_writedata_i[gated_timer_pkg::wrap_flag_pos]) begin
      wrap_interrupt_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      control <= gated_timer_pkg::control_reset;
    end else if (bus_hit && avs_write_i && avs_byteenable_i[0] && avs_address_i == gated_timer_pkg::control_addr) begin
      control <= avs_writedata_i[7:0];
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (avs_address_i == gated_timer_pkg::count_low_addr) begin
      next_readdata[7:0] = count[7:0];
    end else if (avs_address_i == gated_timer_pkg::count_high_addr) begin
      next_readdata[7:0] = count[15:8];
    end else if (avs_address_i == gated_timer_pkg::control_addr) begin
      next_readdata[7:0] = control;
    end else if (avs_address_i == gated_timer_pkg::status_addr) begin
      next_readdata[gated_timer_pkg::wrap_flag_pos] = wrap_interrupt_flag;
      next_readdata[gated_timer_pkg::timebase_ok_pos] = timebase_valid_o;
      next_readdata[gated_timer_pkg::crystal_active_pos] = crystal_osc_enable_o;
    end
  end

  // read data is caught at the take edge and held until the next request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (bus_state == gated_timer_pkg::bus_idle && (avs_read_i || avs_write_i)) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // fixed three-state answer: idle, ack (waitrequest low), done
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_state <= gated_timer_pkg::bus_idle;
      avs_waitrequest_o <= 1'b1;
    end else begin
      case (bus_state)
        gated_timer_pkg::bus_idle: begin
          if (avs_read_i || avs_write_i) begin
            bus_state <= gated_timer_pkg::bus_ack;
            avs_waitrequest_o <= 1'b0;
          end
        end
        gated_timer_pkg::bus_ack: begin
          bus_state <= gated_timer_pkg::bus_done;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_state <= gated_timer_pkg::bus_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crystal_osc_enable_o <= 1'b0;
    end else begin
      crystal_osc_enable_o <= control.crystal_enable_bit && crystal_usable; // see (RL10)
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wrap_interrupt_o <= 1'b0;
    end else begin
      wrap_interrupt_o <= wrap_interrupt_flag; // see (RL18)
    end
  end

  // wake only matters while asleep; awake software sees the flag itself
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= wrap_interrupt_flag && sleep_i; // see (RL15)
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timebase_valid_o <= 1'b0;
    end else begin
      timebase_valid_o <= timebase_next;
    end
  end

  // forced view hides the pins from software while the crystal owns them
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_view_o <= '0;
    end else if (control.crystal_enable_bit && crystal_usable) begin
      port_view_o <= 4'hc; // see (RL12)
    end else begin
      port_view_o <= {pin5_direction_sw_i, pin4_direction_sw_i, pin5_data_raw_i, pin4_data_raw_i};
    end
  end

endmodule // gated_sixteen_bit_timer
`default_nettype wire

// file: core/gated_timer_pkg.sv
package gated_timer_pkg;

  // register byte addresses (word aligned)
  localparam logic [3:0] count_low_addr = 4'h0;
  localparam logic [3:0] count_high_addr = 4'h4;
  localparam logic [3:0] control_addr = 4'h8;
  localparam logic [3:0] status_addr = 4'hc;

  // control register field positions
  localparam int run_enable_pos = 0;
  localparam int source_select_pos = 1;
  localparam int sync_disable_pos = 2;
  localparam int crystal_enable_pos = 3;
  localparam int prescale_lo_pos = 4;
  localparam int alternate_source_pos = 6;
  localparam int internal_oscillator_mode_pos = 7;

  // status register field positions
  localparam int wrap_flag_pos = 0;
  localparam int timebase_ok_pos = 1;
  localparam int crystal_active_pos = 2;

  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [2:0] prescale_reset = 3'h0;

  // fosc/4 instruction cycle: one enable every 4 clocks
  localparam int instr_div = 4;
  localparam logic [1:0] instr_div_last = 2'(instr_div - 1);

  typedef enum logic [2:0] {
    bus_idle = 3'b001,
    bus_ack = 3'b010,
    bus_done = 3'b100
  } bus_state_e;

  typedef struct packed {
    logic internal_oscillator_mode;
    logic alternate_source_bit;
    logic [1:0] prescale_select_field;
    logic crystal_enable_bit;
    logic sync_disable_bit;
    logic source_select_bit;
    logic run_enable_bit;
  } control_s;

  typedef struct packed {
    logic pin5_direction_bit;
    logic pin4_direction_bit;
    logic pin5_data_bit;
    logic pin4_data_bit;
  } port_view_s;

endpackage

// file: tb/count_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module count_source_model (
  input wire logic crystal_enable_i,
  output logic count_pin_o,
  output logic crystal_clock_o
);
  initial count_pin_o = 1'b0;
  initial crystal_clock_o = 1'b0;
  // short half period stands in for the slow crystal; still while disabled
  always #37 crystal_clock_o = crystal_enable_i ? ~crystal_clock_o : 1'b0;
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      #40 count_pin_o <= 1'b1;
      #40 count_pin_o <= 1'b0;
    end
  endtask
endmodule // count_source_model
`default_nettype wire

// file: tb/gated_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gated_timer_asserts (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic sleep_i,
  input wire logic crystal_osc_enable_o,
  input wire logic wrap_interrupt_o,
  input wire logic wake_o,
  input wire gated_timer_pkg::port_view_s port_view_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_ack_spacing: assert property (!avs_waitrequest_o |=> avs_waitrequest_o [*2]) else $error("ack spacing");
  a_read_answer: assert property ($rose(avs_read_i) |=> !avs_waitrequest_o) else $error("read late");
  a_write_answer: assert property ($rose(avs_write_i) |=> !avs_waitrequest_o) else $error("write late");
  a_ack_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i)) else $error("ack");
  a_rdata_held: assert property (avs_waitrequest_o && $past(avs_waitrequest_o) |-> $stable(avs_readdata_o))
    else $error("read data moved");
  a_wake_sleep: assert property (wake_o |-> $past(sleep_i) && wrap_interrupt_o) else $error("wake");
  a_pins_forced: assert property (crystal_osc_enable_o && $past(crystal_osc_enable_o) |-> port_view_o == 4'hc)
    else $error("pins not forced");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0) else $error("upper read bits");
  c_wrap: cover property ($rose(wrap_interrupt_o));
  c_wake: cover property (wake_o);
  c_crystal: cover property ($rose(crystal_osc_enable_o));
endmodule // gated_timer_asserts
bind gated_sixteen_bit_timer gated_timer_asserts chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .sleep_i(sleep_i), .crystal_osc_enable_o(crystal_osc_enable_o),
  .wrap_interrupt_o(wrap_interrupt_o), .wake_o(wake_o), .port_view_o(port_view_o));
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic sleep_i = 1'b0;
  logic lp_osc = 1'b0;
  logic [3:0] raw = 4'h3;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, pin, xtal, xtal_en, irq, wake_o, tbv;
  gated_timer_pkg::port_view_s port_view_o;
  logic [7:0] q;
  logic [7:0] v;
  int fails = 0;
  int num_checks = 0;
  always #2.5 clk_i = ~clk_i;
  gated_sixteen_bit_timer dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .external_count_pin_i(pin), .crystal_clock_i(xtal), .sleep_i(sleep_i), .lp_osc_mode_i(lp_osc),
    .pin5_direction_sw_i(raw[3]), .pin4_direction_sw_i(raw[2]), .pin5_data_raw_i(raw[1]),
    .pin4_data_raw_i(raw[0]), .crystal_osc_enable_o(xtal_en), .wrap_interrupt_o(irq), .wake_o(wake_o),
    .timebase_valid_o(tbv), .port_view_o(port_view_o));
  count_source_model src (.crystal_enable_i(xtal_en), .count_pin_o(pin), .crystal_clock_o(xtal));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (k >= 50) begin
      fails++;
      conclude();
    end
    @(posedge clk_i);
  endtask
  task automatic t_reset;
    logic [3:0] a [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h1};
    bus(1'b1, 4'h1, 8'hff);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, a[i], 8'h0);
      check("reset read", q, (a[i] == 4'hc) ? 16'h2 : 16'h0);
    end
  endtask
  task automatic t_bytes;
    bus(1'b1, 4'h0, 8'h5a);
    bus(1'b1, 4'h4, 8'ha5);
    avs_byteenable_i <= 4'h0;
    bus(1'b1, 4'h0, 8'h11);
    avs_byteenable_i <= 4'h1;
    bus(1'b0, 4'h0, 8'h0);
    check("low byte", q, 16'h5a);
    bus(1'b0, 4'h4, 8'h0);
    check("high byte", q, 16'ha5);
  endtask
  task automatic t_prescale;
    int div;
    for (int m = 0; m < 5; m++) begin
      div = (m == 4) ? 1 : 4 << m;
      bus(1'b1, 4'h0, 8'h0);
      bus(1'b1, 4'h8, (m == 4) ? 8'h41 : {2'b00, 2'(m), 4'h1});
      repeat (32 * div) @(posedge clk_i);
      bus(1'b1, 4'h8, 8'h0);
      bus(1'b0, 4'h0, 8'h0);
      v = q;
      // bus overhead adds up to a few fast ticks
      check("prescaled", 16'(q >= 31 && q <= 36), 16'h1);
      repeat (40) @(posedge clk_i);
      bus(1'b0, 4'h0, 8'h0);
      check("stopped", q, 16'(v));
    end
  endtask
  task automatic t_external;
    bus(1'b1, 4'h0, 8'h0);
    bus(1'b1, 4'h8, 8'h03);
    src.pulses(5);
    repeat (10) @(posedge clk_i);
    bus(1'b0, 4'h0, 8'h0);
    check("sync count", q, 16'h4);
    check("sync timebase", tbv, 16'h1);
    bus(1'b1, 4'h8, 8'h07);
    src.pulses(5);
    repeat (10) @(posedge clk_i);
    bus(1'b0, 4'h0, 8'h0);
    check("async count", 16'(q >= 8 && q <= 10), 16'h1);
    check("async timebase", tbv, 16'h0);
    bus(1'b0, 4'hc, 8'h0);
    check("status timebase", q[1], 16'h0);
  endtask
  task automatic t_wrap;
    bus(1'b1, 4'h4, 8'hff);
    bus(1'b1, 4'h0, 8'hfe);
    sleep_i <= 1'b1;
    src.pulses(3);
    repeat (10) @(posedge clk_i);
    check("wake", {irq, wake_o}, 16'h3);
    bus(1'b0, 4'h0, 8'h0);
    check("wrapped", q, 16'h0);
    bus(1'b0, 4'hc, 8'h0);
    check("flag", q[0], 16'h1);
    sleep_i <= 1'b0;
    bus(1'b1, 4'hc, 8'h01);
    bus(1'b0, 4'hc, 8'h0);
    check("flag clear", {q[0], irq}, 16'h0);
    bus(1'b1, 4'h8, 8'h01);
    sleep_i <= 1'b1;
    bus(1'b0, 4'h0, 8'h0);
    v = q;
    repeat (40) @(posedge clk_i);
    bus(1'b0, 4'h0, 8'h0);
    check("sleep frozen", q, 16'(v));
    sleep_i <= 1'b0;
  endtask
  task automatic t_crystal;
    bus(1'b1, 4'h8, 8'hc0);
    repeat (2) @(posedge clk_i);
    check("fosc timebase", tbv, 16'h0);
    bus(1'b1, 4'h8, 8'h08);
    repeat (4) @(posedge clk_i);
    check("crystal refused", xtal_en, 16'h0);
    lp_osc <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("crystal lp mode", xtal_en, 16'h1);
    lp_osc <= 1'b0;
    bus(1'b1, 4'h8, 8'h88);
    repeat (4) @(posedge clk_i);
    check("crystal on", {xtal_en, port_view_o}, 16'h1c);
    repeat (200) @(posedge clk_i);
    bus(1'b1, 4'h0, 8'h0);
    bus(1'b1, 4'h8, 8'h8f);
    repeat (100) @(posedge clk_i);
    bus(1'b0, 4'h0, 8'h0);
    check("crystal counts", 16'(q != 0), 16'h1);
    bus(1'b1, 4'h8, 8'h0);
    repeat (4) @(posedge clk_i);
    check("crystal off", {xtal_en, port_view_o}, 16'h3);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_bytes();
    t_prescale();
    t_external();
    t_wrap();
    t_crystal();
    conclude();
  end
endmodule // testbench
`default_nettype wire
